// File: src/tppio_map.svh
// register offsets, reset values and field positions of the pin block
`ifndef TPPIO_MAP_SVH
`define TPPIO_MAP_SVH
`define TPPIO_OFF_OUT_A 8'h00
`define TPPIO_OFF_OUT_B 8'h01
`define TPPIO_OFF_OUT_C 8'h02
`define TPPIO_OFF_DIR_A 8'h04
`define TPPIO_OFF_IN_A 8'h09
`define TPPIO_OFF_IN_B 8'h0a
`define TPPIO_OFF_IN_C 8'h0b
`define TPPIO_OFF_DIR_B 8'h0d
`define TPPIO_OFF_ANALOG_B 8'h0e
`define TPPIO_OFF_DIR_C 8'h0f
`define TPPIO_DIR_RESET 8'hff
`define TPPIO_ANALOG_RESET 8'hff
`define TPPIO_OUT_RESET 8'h00
`define TPPIO_C_MASK 8'h0f
`define TPPIO_SHARED_BIT 3'h7
`define TPPIO_TIMER0_CLK_BIT 3'h5
`endif

// File: src/tppio_pkg.sv
// types of the pin block
package tppio_pkg;
    typedef logic [7:0] tppio_byte_t;
    // one pin group: output level, output enable
    typedef struct packed {
        tppio_byte_t level;
        tppio_byte_t enable;
    } tppio_drive_t;
    // register space selected by the load instruction
    typedef enum logic [1:0] {
        TPPIO_SPACE_CONF = 2'b00,
        TPPIO_SPACE_INPUT = 2'b01,
        TPPIO_SPACE_OUTPUT = 2'b10
    } tppio_space_t;
    // owner of the shared pin
    typedef enum logic [0:0] {
        TPPIO_SHARED_TO_A = 1'b0,
        TPPIO_SHARED_TO_B = 1'b1
    } tppio_owner_t;
endpackage

// File: src/tppio_block.sv
// three-port pin block with direction, sampling, output latches and analog select
`timescale 1ns/1ps
`include "tppio_map.svh"

// Function
// (RULE1) nineteen pins in three ports
// (RULE2) ports A and B are seven or eight bits
// (RULE3) shared pin belongs to exactly one port
// (RULE4) port C is four bits, pins zero to three
// (RULE5) pin is never input and output together
// (RULE6) direction and alternate registers per port; only port B has an alternate register here (analog_b)
// (RULE7) direction bit one means input mode
// (RULE8) direction bit zero means output mode
// (RULE9) pins sampled continuously into input registers
// (RULE10) input bit read by load-to-RAM instruction
// (RULE11) output latches written by two load forms
// (RULE12) software sets peripheral input pins to input
// (RULE13) timer0 external clock needs direction bit five set
// (RULE14) analog-selected pin driver forced to tristate
// (RULE15) converter select routes one pin to rail
// (RULE16) keep pins quiet during a conversion
// (RULE17) analog register bit one makes B pin analog
// (RULE18) direction bits reset to one, drivers off
// (RULE19) drive latch only when output and digital
module tppio_block #(
    parameter int ANALOG_SEL_W = 3
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // configuration register port (load instructions of the core)
    input wire logic conf_wr_in,
    input wire logic [7:0] conf_addr_in,
    input wire tppio_pkg::tppio_byte_t conf_wdata_in,
    output logic [7:0] conf_rdata_out,
    // output register port (immediate and register forms)
    input wire logic out_load_immediate_form_in,
    input wire logic out_load_register_form_in,
    input wire logic [7:0] out_addr_in,
    input wire tppio_pkg::tppio_byte_t out_immediate_in,
    input wire tppio_pkg::tppio_byte_t out_register_in,
    // input sample register bit fetch for load-to-RAM
    input wire logic input_to_ram_load_in,
    input wire logic [7:0] in_addr_in,
    input wire logic [2:0] in_bit_in,
    output logic input_bit_valid_out,
    output logic input_bit_out,
    // shared pin owner and converter channel select
    input wire tppio_pkg::tppio_owner_t shared_owner_in,
    input wire logic [ANALOG_SEL_W-1:0] analog_channel_in,
    // pins
    input wire tppio_pkg::tppio_byte_t first_port_pins_in,
    input wire tppio_pkg::tppio_byte_t second_port_pins_in,
    input wire logic [3:0] third_port_pins_in,
    output tppio_pkg::tppio_drive_t first_port_pins_out,
    output tppio_pkg::tppio_drive_t second_port_pins_out,
    output logic [3:0] third_port_pins_out,
    output logic [3:0] third_port_pins_oe_out,
    // analog rail to the converter input (selected pin index, one-hot)
    output tppio_pkg::tppio_byte_t analog_route_out
);
    import tppio_pkg::*;

    // ========================================
    // decode helpers shared by several ports

    // one-hot decode of a configuration address; write and readback share it
    function automatic logic [3:0] conf_hit(input logic [7:0] addr);
        case (addr)
            `TPPIO_OFF_DIR_A: conf_hit = 4'h1;
            `TPPIO_OFF_DIR_B: conf_hit = 4'h2;
            `TPPIO_OFF_ANALOG_B: conf_hit = 4'h4;
            `TPPIO_OFF_DIR_C: conf_hit = 4'h8;
            default: conf_hit = 4'h0;
        endcase
    endfunction

    // a pin drives when it is owned, in output mode and digital
    function automatic tppio_byte_t drive_mask(input tppio_byte_t dir, input tppio_byte_t own,
            input tppio_byte_t analog);
        drive_mask = ~dir & own & ~analog;
    endfunction

    // a pin reports its level when it is owned, in input mode and digital
    function automatic tppio_byte_t sample_mask(input tppio_byte_t dir, input tppio_byte_t own,
            input tppio_byte_t analog);
        sample_mask = dir & own & ~analog;
    endfunction

    // ========================================
    // register file
    tppio_byte_t dir_a, dir_b, dir_c, analog_b;
    tppio_byte_t out_a, out_b, out_c;
    tppio_byte_t next_dir_a, next_dir_b, next_dir_c, next_analog_b;
    tppio_byte_t next_out_a, next_out_b, next_out_c;
    tppio_byte_t out_value;
    logic out_load;
    logic [3:0] conf_sel;

    // either output load form writes the latch; the register form wins a tie
    always_comb begin
        out_load = out_load_immediate_form_in | out_load_register_form_in; // see (RULE11)
        out_value = out_load_register_form_in ? out_register_in : out_immediate_in;
    end

    // configuration address decode, shared by write and readback
    always_comb begin
        conf_sel = conf_hit(conf_addr_in);
    end

    // next values of configuration and output latches
    always_comb begin
        next_dir_a = dir_a;
        next_dir_b = dir_b;
        next_dir_c = dir_c;
        next_analog_b = analog_b;
        next_out_a = out_a;
        next_out_b = out_b;
        next_out_c = out_c;
        // unmapped addresses hit nothing and are ignored
        if (conf_wr_in && conf_sel[0]) begin
            next_dir_a = conf_wdata_in; // see (RULE6)
        end
        if (conf_wr_in && conf_sel[1]) begin
            next_dir_b = conf_wdata_in;
        end
        if (conf_wr_in && conf_sel[2]) begin
            next_analog_b = conf_wdata_in; // see (RULE17)
        end
        if (conf_wr_in && conf_sel[3]) begin
            next_dir_c = conf_wdata_in | ~`TPPIO_C_MASK; // see (RULE4)
        end
        if (out_load) begin
            case (out_addr_in)
                `TPPIO_OFF_OUT_A: next_out_a = out_value; // see (RULE11)
                `TPPIO_OFF_OUT_B: next_out_b = out_value;
                `TPPIO_OFF_OUT_C: next_out_c = out_value;
                default: ;
            endcase
        end
    end

    // register update; every pin comes up as input with driver off
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dir_a <= `TPPIO_DIR_RESET; // see (RULE18)
            dir_b <= `TPPIO_DIR_RESET;
            dir_c <= `TPPIO_DIR_RESET;
            analog_b <= `TPPIO_ANALOG_RESET;
            out_a <= `TPPIO_OUT_RESET;
            out_b <= `TPPIO_OUT_RESET;
            out_c <= `TPPIO_OUT_RESET;
        end else begin
            dir_a <= next_dir_a;
            dir_b <= next_dir_b;
            dir_c <= next_dir_c;
            analog_b <= next_analog_b;
            out_a <= next_out_a;
            out_b <= next_out_b;
            out_c <= next_out_c;
        end
    end

    // ========================================
    // configuration readback (output latches are write-only)
    always_comb begin
        conf_rdata_out = 8'h00; // unmapped reads give zero
        case (conf_sel)
            4'h1: conf_rdata_out = dir_a;
            4'h2: conf_rdata_out = dir_b;
            4'h4: conf_rdata_out = analog_b;
            4'h8: conf_rdata_out = dir_c;
            default: conf_rdata_out = 8'h00;
        endcase
    end

    // ========================================
    // shared pin ownership and effective pin enables
    tppio_byte_t own_a, own_b;
    tppio_byte_t en_a, en_b;

    // the shared pin is live in exactly one port; seven pins otherwise
    always_comb begin
        own_a = 8'hff;
        own_b = 8'hff;
        if (shared_owner_in == TPPIO_SHARED_TO_A) begin
            own_b[`TPPIO_SHARED_BIT] = 1'b0; // see (RULE3)
        end else begin
            own_a[`TPPIO_SHARED_BIT] = 1'b0; // see (RULE2)
        end
        // driver only for owned, output-mode, digital pins
        en_a = drive_mask(dir_a, own_a, 8'h00); // see (RULE8)
        en_b = drive_mask(dir_b, own_b, analog_b); // see (RULE14) (RULE19)
    end

    // ========================================
    // sampled input registers, taken every clock
    tppio_byte_t in_a, in_b, in_c;
    tppio_byte_t next_in_a, next_in_b, next_in_c;

    // owned, input-mode, digital pins report the pin; output, unowned and analog pins read zero
    always_comb begin
        next_in_a = first_port_pins_in & sample_mask(dir_a, own_a, 8'h00); // see (RULE7) (RULE5)
        next_in_b = second_port_pins_in & sample_mask(dir_b, own_b, analog_b);
        next_in_c = {4'h0, third_port_pins_in} & dir_c & `TPPIO_C_MASK; // see (RULE9)
    end

    // sample registers clear on reset, then follow the pins
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            in_a <= 8'h00;
            in_b <= 8'h00;
            in_c <= 8'h00;
        end else begin
            in_a <= next_in_a;
            in_b <= next_in_b;
            in_c <= next_in_c;
        end
    end

    // ========================================
    // load-to-RAM bit fetch: one bit of a sample register, registered
    logic next_bit_valid, next_bit;
    logic bit_valid, bit_q;
    tppio_byte_t sel_in;

    function automatic tppio_byte_t select_input(input logic [7:0] addr,
            input tppio_byte_t a, input tppio_byte_t b, input tppio_byte_t c);
        case (addr)
            `TPPIO_OFF_IN_A: select_input = a;
            `TPPIO_OFF_IN_B: select_input = b;
            `TPPIO_OFF_IN_C: select_input = c;
            default: select_input = 8'h00;
        endcase
    endfunction

    // pick the addressed sample register, then the requested bit
    always_comb begin
        sel_in = select_input(in_addr_in, in_a, in_b, in_c);
        next_bit_valid = input_to_ram_load_in; // see (RULE10)
        next_bit = sel_in[in_bit_in];
    end

    // answer stands for one cycle after the request
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bit_valid <= 1'b0;
            bit_q <= 1'b0;
        end else begin
            bit_valid <= next_bit_valid;
            bit_q <= next_bit;
        end
    end

    // ========================================
    // analog multiplexer: one selected analog pin onto the rail
    tppio_byte_t route;
    tppio_byte_t next_route;

    // only the selected channel, and only if it is analog
    always_comb begin
        next_route = 8'h00;
        next_route[analog_channel_in] = analog_b[analog_channel_in]; // see (RULE15)
    end

    // rail selection registered; nothing routed after reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            route <= 8'h00;
        end else begin
            route <= next_route;
        end
    end

    // ========================================
    // per-pin drive cells: a level reaches a pin only while its driver is on
    tppio_byte_t lvl_a, lvl_b;
    logic [3:0] lvl_c, en_c;

    // ports A and B: owned, output-mode, digital pins drive
    for (genvar p = 0; p < 8; p = p + 1) begin : g_pin_ab
        assign lvl_a[p] = out_a[p] & en_a[p]; // see (RULE19)
        assign lvl_b[p] = out_b[p] & en_b[p];
    end

    // port C: four pins, no shared pin and no analog option
    for (genvar p = 0; p < 4; p = p + 1) begin : g_pin_c
        assign en_c[p] = ~dir_c[p]; // see (RULE8)
        assign lvl_c[p] = out_c[p] & en_c[p];
    end

    // ========================================
    // pin drive outputs
    always_comb begin
        first_port_pins_out.level = lvl_a;
        first_port_pins_out.enable = en_a; // see (RULE1)
        second_port_pins_out.level = lvl_b;
        second_port_pins_out.enable = en_b;
        third_port_pins_out = lvl_c;
        third_port_pins_oe_out = en_c; // see (RULE4)
        input_bit_valid_out = bit_valid;
        input_bit_out = bit_q;
        analog_route_out = route;
    end

endmodule

// File: verification/tppio_props.sv
// port assertions of the pin block
`timescale 1ns/1ps
`include "tppio_map.svh"
// ========
// checker
module tppio_props (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register ports
    input wire logic conf_wr_in,
    input wire logic [7:0] conf_addr_in,
    input wire tppio_pkg::tppio_byte_t conf_wdata_in,
    input wire logic [7:0] conf_rdata_out,
    input wire logic input_to_ram_load_in,
    input wire logic input_bit_valid_out,
    // pins
    input wire tppio_pkg::tppio_owner_t shared_owner_in,
    input wire tppio_pkg::tppio_drive_t first_port_pins_out,
    input wire tppio_pkg::tppio_drive_t second_port_pins_out,
    input wire logic [3:0] third_port_pins_oe_out,
    input wire tppio_pkg::tppio_byte_t analog_route_out
);
    import tppio_pkg::*;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // drivers, fetch answer, direction, analog and ownership
    AST_RESET_OFF: assert property (disable iff (1'b0) rst_in |=> {first_port_pins_out.enable,
        second_port_pins_out.enable, third_port_pins_oe_out} == 20'h0) else $error("driver on after reset");
    AST_FETCH_ANSWER: assert property (input_to_ram_load_in |=> input_bit_valid_out)
        else $error("fetch not answered");
    AST_FETCH_CAUSE: assert property (input_bit_valid_out |-> $past(input_to_ram_load_in))
        else $error("answer without fetch");
    AST_DIR_A: assert property (conf_wr_in && conf_addr_in == `TPPIO_OFF_DIR_A |=>
        first_port_pins_out.enable[6:0] == ~$past(conf_wdata_in[6:0])) else $error("port a enable");
    AST_DIR_C: assert property (conf_wr_in && conf_addr_in == `TPPIO_OFF_DIR_C |=>
        third_port_pins_oe_out == ~$past(conf_wdata_in[3:0])) else $error("port c enable");
    AST_ANALOG_TRI: assert property (conf_wr_in && conf_addr_in == `TPPIO_OFF_ANALOG_B |=>
        (second_port_pins_out.enable & $past(conf_wdata_in)) == 8'h00) else $error("analog pin driven");
    AST_SHARED_ONE: assert property (!(first_port_pins_out.enable[7] && second_port_pins_out.enable[7]))
        else $error("shared pin driven twice");
    AST_OWNER_B: assert property (shared_owner_in == TPPIO_SHARED_TO_B |->
        !first_port_pins_out.enable[7]) else $error("port a drives shared pin");
    AST_C_UPPER: assert property (conf_addr_in == `TPPIO_OFF_DIR_C |-> conf_rdata_out[7:4] == 4'hf)
        else $error("port c upper bits");
    AST_ROUTE_ONE: assert property ($onehot0(analog_route_out))
        else $error("route not one-hot");
    // main scenarios
    COV_FETCH: cover property (input_to_ram_load_in ##1 input_to_ram_load_in);
    COV_ROUTE: cover property (analog_route_out != 8'h00);
    COV_SHARED_B: cover property (second_port_pins_out.enable[7]);
endmodule

bind tppio_block tppio_props u_tppio_props (.clk_in(clk_in), .rst_in(rst_in),
    .conf_wr_in(conf_wr_in), .conf_addr_in(conf_addr_in), .conf_wdata_in(conf_wdata_in),
    .conf_rdata_out(conf_rdata_out), .input_to_ram_load_in(input_to_ram_load_in),
    .input_bit_valid_out(input_bit_valid_out), .shared_owner_in(shared_owner_in),
    .first_port_pins_out(first_port_pins_out), .second_port_pins_out(second_port_pins_out),
    .third_port_pins_oe_out(third_port_pins_oe_out), .analog_route_out(analog_route_out));

// File: verification/tppio_board.sv
// board model of the port pins
`timescale 1ns/1ps
module tppio_board (
    // device drive and board pattern
    input wire tppio_pkg::tppio_drive_t drv_a_in,
    input wire tppio_pkg::tppio_drive_t drv_b_in,
    input wire logic [3:0] lvl_c_in,
    input wire logic [3:0] oe_c_in,
    input wire tppio_pkg::tppio_byte_t ext_in,
    // resolved wire levels
    output tppio_pkg::tppio_byte_t pin_a_out,
    output tppio_pkg::tppio_byte_t pin_b_out,
    output logic [3:0] pin_c_out
);
    import tppio_pkg::*;
    // driven pin shows the device level, a free pin the board pattern (inverted on B, xor 4'ha on C; no pull-ups)
    assign pin_a_out = (drv_a_in.enable & drv_a_in.level) | (~drv_a_in.enable & ext_in);
    assign pin_b_out = (drv_b_in.enable & drv_b_in.level) | (~drv_b_in.enable & ~ext_in);
    assign pin_c_out = (oe_c_in & lvl_c_in) | (~oe_c_in & (ext_in[3:0] ^ 4'ha));
endmodule

// File: verification/tppio_block_bench.sv
// self-checking bench of the pin block
`timescale 1ns/1ps
module tppio_block_bench;
    import tppio_pkg::*;
    logic clk_in = 0, rst_in = 1, wr = 0, ldi = 0, ldr = 0, req = 0, valid, bitv;
    logic [7:0] ca = 0, oa = 0, ia = 0, rdata;
    logic [2:0] ib = 0, chan = 0, bi;
    tppio_byte_t wd = 0, imm = 0, rgd = 0, ext = 0, route, pa, pb, da, db, dc, an, la, lb, lc, ma, mb;
    tppio_owner_t owner = TPPIO_SHARED_TO_A;
    tppio_drive_t a_drv, b_drv;
    logic [3:0] pc, c_lvl, c_oe;
    logic q[$];
    int seed = 6092, err_total = 0, n_compared = 0;
    tppio_block u_tppio_block (.clk_in(clk_in), .rst_in(rst_in), .conf_wr_in(wr), .conf_addr_in(ca),
        .conf_wdata_in(wd), .conf_rdata_out(rdata), .out_load_immediate_form_in(ldi),
        .out_load_register_form_in(ldr), .out_addr_in(oa), .out_immediate_in(imm),
        .out_register_in(rgd), .input_to_ram_load_in(req), .in_addr_in(ia), .in_bit_in(ib),
        .input_bit_valid_out(valid), .input_bit_out(bitv), .shared_owner_in(owner),
        .analog_channel_in(chan), .first_port_pins_in(pa), .second_port_pins_in(pb),
        .third_port_pins_in(pc), .first_port_pins_out(a_drv), .second_port_pins_out(b_drv),
        .third_port_pins_out(c_lvl), .third_port_pins_oe_out(c_oe), .analog_route_out(route));
    tppio_board u_tppio_board (.drv_a_in(a_drv), .drv_b_in(b_drv), .lvl_c_in(c_lvl),
        .oe_c_in(c_oe), .ext_in(ext), .pin_a_out(pa), .pin_b_out(pb), .pin_c_out(pc));
    // ========
    // tasks
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic conf(input logic [7:0] a, input tppio_byte_t d);
        @(negedge clk_in);
        ca = a;
        wd = d;
        wr = 1;
        @(negedge clk_in);
        wr = 0;
    endtask
    task automatic load(input logic [7:0] a, input tppio_byte_t d, input int m);
        @(negedge clk_in);
        oa = a;
        rgd = d;
        imm = (m == 2) ? ~d : d;
        ldi = (m != 1);
        ldr = (m != 0);
        @(negedge clk_in);
        {ldi, ldr} = 2'b00;
    endtask
    task automatic fetch(input logic [7:0] a, input logic e);
        @(negedge clk_in);
        ia = a;
        ib = bi;
        req = 1;
        q.push_back(e);
    endtask
    // clock and watchdog
    initial forever #12.5 clk_in = ~clk_in;
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
    // answer monitor takes the oldest note
    always @(negedge clk_in) if (valid === 1'b1) check(bitv, q.size() ? q.pop_front() : ~bitv);
    // ========
    // main sequence
    initial begin
        repeat (8) @(negedge clk_in);
        rst_in = 0;
        check({a_drv.enable, b_drv.enable, c_oe}, 0);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_in);
            ca = (i == 4) ? 8'h04 : 8'(i + 8);
            #1 check(rdata, (i >= 4) ? 8'hff : 8'h00);
        end
        for (int r = 0; r < 20; r++) begin
            @(negedge clk_in);
            owner = tppio_owner_t'(r[0]);
            chan = $random(seed);
            ext = $random(seed);
            {da, db, dc, an} = $random(seed);
            {la, lb, lc} = $random(seed);
            if (r == 0) da[5] = 1'b1;
            conf(8'h04, da);
            conf(8'h0d, db);
            conf(8'h0f, dc);
            conf(8'h0e, an);
            load(8'h00, la, r % 3);
            load(8'h01, lb, (r + 1) % 3);
            load(8'h02, lc, (r + 2) % 3);
            ma = {owner == TPPIO_SHARED_TO_A, 7'h7f};
            mb = {owner == TPPIO_SHARED_TO_B, 7'h7f};
            check({a_drv.enable, b_drv.enable, c_oe}, {~da & ma, ~db & ~an & mb, ~dc[3:0]});
            check({a_drv.level & a_drv.enable, b_drv.level & b_drv.enable, c_lvl & c_oe},
                {la & ~da & ma, lb & ~db & ~an & mb, lc[3:0] & ~dc[3:0]});
            check(route, an[chan] ? 8'h01 << chan : 8'h00);
            ca = 8'h0f;
            #1 check(rdata, dc | 8'hf0);
            conf(8'h0e, 8'h00);
            repeat (2) @(negedge clk_in);
            bi = $random(seed);
            fetch(8'h09, ext[bi] & da[bi] & ma[bi]);
            fetch(8'h0a, ~ext[bi] & db[bi] & mb[bi]);
            fetch(8'h0b, bi < 4 && ((ext[bi] ^ bi[0]) & dc[bi]));
            fetch(8'h05, 1'b0);
            @(negedge clk_in) req = 0;
        end
        repeat (3) @(negedge clk_in);
        check(q.size(), 0);
        give_verdict();
    end
endmodule
